// ==== logic/stc_cfg.svh ====
// Purpose: constants of the serial to 2-wire command bridge
// Assumes: 40 MHz system clock, 6.25 MHz link clock, 57600 baud
// Notes: types live in stc_pkg
`ifndef STC_CFG_SVH
`define STC_CFG_SVH
`define STC_CLK_HZ 40000000
`define STC_LINK_HZ 6250000
`define STC_BAUD 57600
`define STC_BAUD_DIV (`STC_LINK_HZ / `STC_BAUD)
`define STC_TWI_HZ 100000
`define STC_TWI_QTR (`STC_CLK_HZ / (4 * `STC_TWI_HZ))
`define STC_C_START 8'hA0
`define STC_C_WRITE 8'hA1
`define STC_C_READ 8'hA2
`define STC_C_STOP 8'hA3
`define STC_C_CLK9 8'hA4
`define STC_C_SETA 8'hA5
`define STC_NIB_PKW 4'h8
`define STC_NIB_PKR 4'h9
`define STC_NIB_SINGLE 4'hA
`define STC_NIB_ACK 4'hB
`define STC_ERR 8'hFA
`define STC_RD_ACK 8'h01
`define STC_ACK_BIT 4'h8
`define STC_UART_STOP 4'h9
`endif

// ==== logic/stc_pkg.sv ====
// Purpose: types and helpers of the command bridge
// Assumes: stc_cfg.svh on the include path
// Notes: one-hot state codes
`default_nettype none
`include "stc_cfg.svh"
package stc_pkg;
	typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_ARG = 5'h02,
		ST_DATA = 5'h04, ST_BUS = 5'h08, ST_TX = 5'h10} stc_state_t;
	typedef enum logic [9:0] {Q_START = 10'h001, Q_DEVW = 10'h002,
		Q_MADDR = 10'h004, Q_WDATA = 10'h008, Q_RSTART = 10'h010,
		Q_DEVR = 10'h020, Q_RDATA = 10'h040, Q_STOP = 10'h080,
		Q_CLK9 = 10'h100, Q_REPLY = 10'h200} stc_step_t;

	function automatic logic stc_is_pkt(input logic [7:0] c);
		return c[7:4] == `STC_NIB_PKW || c[7:4] == `STC_NIB_PKR;
	endfunction

	// Success code: packets echo the command, single ones get 0xB_
	function automatic logic [7:0] stc_reply(input logic [7:0] c);
		return stc_is_pkt(c) ? c : {`STC_NIB_ACK, c[3:0]};
	endfunction

	// Line pull-downs {scl, sda} for one quarter of a bus bit
	function automatic logic [1:0] stc_lines(input logic [1:0] kind,
		input logic [1:0] ph, input logic low);
		logic [1:0] v;
		v = {!ph[0] ^ ph[1], low};
		if (kind == 2'h1) begin
			v = {ph == 2'h0 || ph == 2'h3, ph[1]};
		end else if (kind == 2'h2) begin
			v = {ph == 2'h0, !ph[1]};
		end
		return v;
	endfunction
endpackage
`default_nettype wire

// ==== logic/stc_link_uart.sv ====
// Purpose: 8N1 serial receiver and transmitter on the link clock
// Assumes: tx_data held stable while a send toggle is pending
// Notes: bytes cross to the system clock by toggles
`default_nettype none
`include "stc_cfg.svh"
module stc_link_uart import stc_pkg::*; #(
	parameter int BAUD_DIV = `STC_BAUD_DIV
) (
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic rxd,
	output logic txd,
	output logic [7:0] rx_data,
	output logic rx_tgl,
	input wire logic [7:0] tx_data,
	input wire logic tx_tgl,
	output logic tx_done
);
	localparam int DW = $clog2(BAUD_DIV);
	initial begin
		if (BAUD_DIV < 4) $error("BAUD_DIV too small");
	end
	typedef struct packed {
		logic [1:0] rs;
		logic [1:0] srx;
		logic [1:0] stx;
		logic rbusy;
		logic [DW-1:0] rcnt;
		logic [3:0] rbit;
		logic [7:0] rsh;
		logic [7:0] rx_data;
		logic rx_tgl;
		logic tbusy;
		logic [DW-1:0] tcnt;
		logic [3:0] tbit;
		logic [9:0] tsh;
		logic tack;
		logic tx_done;
	} stc_uart_t;
	// Receive synchroniser resets to the idle line level, so no false start
	localparam stc_uart_t RST = '{tsh: 10'h3FF, srx: 2'h3, default: '0};
	stc_uart_t r, next_r;

	always_comb begin
		next_r = r;
		next_r.rs = {r.rs[0], rst_n};
		next_r.srx = {r.srx[0], rxd};
		next_r.stx = {r.stx[0], tx_tgl};
		if (r.rbusy) begin
			if (r.rcnt != '0) begin
				next_r.rcnt = r.rcnt - 1'b1;
			end else begin
				next_r.rcnt = DW'(BAUD_DIV - 1);
				next_r.rbit = r.rbit + 1'b1;
				if (r.rbit == 4'h0) begin
					next_r.rbusy = !r.srx[1];
				end else if (r.rbit == `STC_UART_STOP) begin
					next_r.rbusy = 1'b0;
					if (r.srx[1]) begin
						next_r.rx_data = r.rsh;
						next_r.rx_tgl = !r.rx_tgl;
					end
				end else begin
					next_r.rsh = {r.srx[1], r.rsh[7:1]};
				end
			end
		end else if (!r.srx[1]) begin
			next_r.rbusy = 1'b1;
			next_r.rcnt = DW'(BAUD_DIV / 2);
			next_r.rbit = 4'h0;
		end
		if (r.tbusy) begin
			if (r.tcnt != '0) begin
				next_r.tcnt = r.tcnt - 1'b1;
			end else begin
				next_r.tcnt = DW'(BAUD_DIV - 1);
				next_r.tsh = {1'b1, r.tsh[9:1]};
				next_r.tbit = r.tbit + 1'b1;
				if (r.tbit == `STC_UART_STOP) begin
					next_r.tbusy = 1'b0;
					next_r.tx_done = r.tack;
				end
			end
		end else if (r.stx[1] != r.tack) begin
			next_r.tack = r.stx[1];
			next_r.tsh = {1'b1, tx_data, 1'b0};
			next_r.tbusy = 1'b1;
			next_r.tcnt = DW'(BAUD_DIV - 1);
			next_r.tbit = 4'h0;
		end
		if (!r.rs[1]) begin
			next_r = RST;
			next_r.rs = {r.rs[0], rst_n};
		end
	end

	always_ff @(posedge link_clk) begin
		r <= next_r;
	end

	assign txd = r.tsh[0];
	assign rx_data = r.rx_data;
	assign rx_tgl = r.rx_tgl;
	assign tx_done = r.tx_done;

	baud_hold_a: assert property (@(posedge link_clk) disable iff (!r.rs[1])
		r.tbusy && r.tcnt != '0 |=> $stable(r.tsh))
		else $error("tx bit changed before its baud period ended");
endmodule
`default_nettype wire

// ==== logic/stc_bridge.sv ====
// Purpose: host byte commands turned into 2-wire master operations
// Assumes: open-drain bus with pull-ups, host at 57600 baud
// Notes: top module; serial side runs on link_clk
`default_nettype none
`include "stc_cfg.svh"
module stc_bridge import stc_pkg::*; #(
	parameter int QTR = `STC_TWI_QTR,
	parameter int BAUD_DIV = `STC_BAUD_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic rxd,
	output logic txd,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	localparam int QW = $clog2(QTR);
	initial begin
		if (QTR < 8) $error("QTR too small");
	end
	typedef struct packed {
		stc_state_t st;
		stc_step_t step;
		logic [7:0] cmd;
		logic [7:0] arg;
		logic [7:0] dev;
		logic [3:0] cnt;
		logic [3:0] idx;
		logic [15:0][7:0] pbuf;
		logic err;
		logic run;
		logic [1:0] ph;
		logic [QW-1:0] qc;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic nack;
		logic scl_low;
		logic sda_low;
		logic [1:0] sy_scl;
		logic [1:0] sy_sda;
		logic [2:0] sy_rx;
		logic [1:0] sy_txd;
		logic tx_req;
		logic [7:0] tx_data;
		logic last;
	} stc_core_t;
	localparam stc_core_t RST = '{st: ST_IDLE, step: Q_REPLY,
		sy_scl: 2'h3, sy_sda: 2'h3, default: '0};
	stc_core_t r, next_r;
	logic [7:0] rx_data;
	logic rx_tgl;
	logic tx_done;
	logic rx_new, pkt, wr_step, want_nack, low, stall, go;
	logic [1:0] kind;

	stc_link_uart #(.BAUD_DIV(BAUD_DIV)) u_link (
		.link_clk(link_clk),
		.rst_n(rst_n),
		.rxd(rxd),
		.txd(txd),
		.rx_data(rx_data),
		.rx_tgl(rx_tgl),
		.tx_data(r.tx_data),
		.tx_tgl(r.tx_req),
		.tx_done(tx_done)
	);

	always_comb begin
		next_r = r;
		next_r.sy_scl = {r.sy_scl[0], scl_i};
		next_r.sy_sda = {r.sy_sda[0], sda_i};
		next_r.sy_rx = {r.sy_rx[1:0], rx_tgl};
		next_r.sy_txd = {r.sy_txd[0], tx_done};
		rx_new = r.sy_rx[2] != r.sy_rx[1];
		pkt = stc_is_pkt(r.cmd);
		wr_step = r.step inside {Q_DEVW, Q_DEVR, Q_MADDR, Q_WDATA};
		want_nack = pkt ? r.idx == r.cnt : r.arg != `STC_RD_ACK;
		if (r.step == Q_RDATA) begin
			low = r.bitn == `STC_ACK_BIT && !want_nack;
		end else if (wr_step) begin
			low = r.bitn != `STC_ACK_BIT && !r.sh[7];
		end else begin
			low = 1'b0;
		end
		kind = 2'h0;
		if (r.step == Q_START || r.step == Q_RSTART) begin
			kind = 2'h1;
		end else if (r.step == Q_STOP) begin
			kind = 2'h2;
		end
		stall = r.ph == 2'h1 && !r.sy_scl[1];
		go = r.qc == QW'(QTR - 1) && !stall;
		case (r.st)
			ST_IDLE: begin
				if (rx_new) begin
					next_r.cmd = rx_data;
					next_r.st = ST_ARG;
				end
			end
			ST_ARG: begin
				if (rx_new) begin
					next_r.arg = rx_data;
					next_r.err = 1'b0;
					next_r.idx = 4'h0;
					next_r.cnt = r.cmd[3:0];
					next_r.run = 1'b0;
					next_r.st = ST_BUS;
					next_r.step = Q_REPLY;
					if (pkt) begin
						next_r.step = Q_START;
						if (r.cmd[7:4] == `STC_NIB_PKW) next_r.st = ST_DATA;
					end else if (r.cmd == `STC_C_START) begin
						next_r.step = Q_START;
					end else if (r.cmd == `STC_C_WRITE) begin
						next_r.step = Q_WDATA;
					end else if (r.cmd == `STC_C_READ) begin
						next_r.step = Q_RDATA;
					end else if (r.cmd == `STC_C_STOP) begin
						next_r.step = Q_STOP;
					end else if (r.cmd == `STC_C_CLK9) begin
						next_r.step = Q_CLK9;
					end else if (r.cmd == `STC_C_SETA) begin
						if (rx_data[0]) next_r.err = 1'b1;
						else next_r.dev = rx_data;
					end else begin
						next_r.err = 1'b1;
					end
				end
			end
			ST_DATA: begin
				if (rx_new) begin
					next_r.pbuf[r.idx] = rx_data;
					next_r.idx = r.idx + 1'b1;
					if (r.idx == r.cnt) begin
						next_r.idx = 4'h0;
						next_r.st = ST_BUS;
					end
				end
			end
			ST_BUS: begin
				if (!r.run && r.step == Q_REPLY) begin
					next_r.tx_data = r.err ? `STC_ERR : stc_reply(r.cmd);
					next_r.tx_req = !r.tx_req;
					next_r.last = 1'b1;
					next_r.st = ST_TX;
				end else if (!r.run) begin
					next_r.run = 1'b1;
					next_r.ph = 2'h0;
					next_r.qc = '0;
					next_r.bitn = 4'h0;
					next_r.nack = 1'b0;
					case (r.step)
						Q_DEVW: next_r.sh = {r.dev[7:1], 1'b0};
						Q_DEVR: next_r.sh = {r.dev[7:1], 1'b1};
						Q_MADDR: next_r.sh = r.arg;
						Q_WDATA: next_r.sh = pkt ? r.pbuf[r.idx] : r.arg;
						default: next_r.sh = 8'hFF;
					endcase
				end else begin
					{next_r.scl_low, next_r.sda_low} = stc_lines(kind, r.ph, low);
					if (!stall) next_r.qc = go ? '0 : r.qc + 1'b1;
					if (go) begin
						next_r.ph = r.ph + 1'b1;
						if (r.ph == 2'h2 && kind == 2'h0) begin
							if (r.bitn == `STC_ACK_BIT) begin
								if (wr_step) next_r.nack = r.sy_sda[1];
							end else if (r.step == Q_RDATA) begin
								next_r.sh = {r.sh[6:0], r.sy_sda[1]};
							end
						end
						if (r.ph == 2'h3) begin
							if (kind == 2'h0 && r.bitn != `STC_ACK_BIT) begin
								next_r.bitn = r.bitn + 1'b1;
								if (wr_step) next_r.sh = {r.sh[6:0], 1'b0};
							end else begin
								next_r.run = 1'b0;
								if (wr_step && r.nack) begin
									next_r.err = 1'b1;
									next_r.step = pkt ? Q_STOP : Q_REPLY;
								end else if (!pkt) begin
									next_r.step = Q_REPLY;
									if (r.step == Q_RDATA) begin
										next_r.tx_data = r.sh;
										next_r.tx_req = !r.tx_req;
										next_r.last = 1'b0;
										next_r.st = ST_TX;
									end
								end else begin
									case (r.step)
										Q_START: next_r.step = Q_DEVW;
										Q_DEVW: next_r.step = Q_MADDR;
										Q_MADDR: begin
											if (r.cmd[7:4] == `STC_NIB_PKW) next_r.step = Q_WDATA;
											else next_r.step = Q_RSTART;
										end
										Q_WDATA: begin
											if (r.idx == r.cnt) next_r.step = Q_STOP;
											else next_r.idx = r.idx + 1'b1;
										end
										Q_RSTART: next_r.step = Q_DEVR;
										Q_DEVR: next_r.step = Q_RDATA;
										Q_RDATA: begin
											next_r.tx_data = r.sh;
											next_r.tx_req = !r.tx_req;
											next_r.last = 1'b0;
											next_r.st = ST_TX;
											if (r.idx == r.cnt) next_r.step = Q_STOP;
											else next_r.idx = r.idx + 1'b1;
										end
										default: next_r.step = Q_REPLY;
									endcase
								end
							end
						end
					end
				end
			end
			ST_TX: begin
				if (r.sy_txd[1] == r.tx_req) begin
					next_r.st = r.last ? ST_IDLE : ST_BUS;
				end
			end
			default: next_r.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) r <= RST;
		else r <= next_r;
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = r.scl_low;
	assign sda_oe = r.sda_low;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_reply_entry;
		r.st == ST_BUS && !r.run && r.step == Q_REPLY;
	endsequence
	sequence s_maddr_done;
		$past(r.step) == Q_MADDR && r.step != Q_MADDR && !r.err;
	endsequence

	unknown_cmd_a: assert property (r.st == ST_ARG && rx_new &&
		!pkt && r.cmd[7:4] != `STC_NIB_SINGLE |=> r.err && r.step == Q_REPLY)
		else $error("unknown command not flagged as error");
	dev_keep_a: assert property ($changed(r.dev) |->
		$past(r.st) == ST_ARG && $past(r.cmd) == `STC_C_SETA)
		else $error("device address changed without set-address");
	rw_bit_a: assert property (r.run && r.bitn == 4'h7 &&
		(r.step == Q_DEVW || r.step == Q_DEVR) |-> r.sh[7] == (r.step == Q_DEVR))
		else $error("wrong read/write bit in device address");
	buffer_hold_a: assert property (r.st == ST_DATA |=>
		$stable(r.scl_low) && $stable(r.sda_low))
		else $error("bus moved while packet still buffering");
	read_ack_a: assert property (r.run && r.step == Q_RDATA &&
		r.bitn == `STC_ACK_BIT && r.ph == 2'h1 && r.qc != '0 |->
		r.sda_low == !want_nack)
		else $error("wrong ACK or NACK after read byte");
	ack_sample_a: assert property ($past(r.run) && r.run &&
		$changed(r.nack) |-> $past(r.sy_scl[1]))
		else $error("acknowledge sampled with clock low");
	busy_drop_a: assert property (rx_new &&
		(r.st == ST_BUS || r.st == ST_TX) |=> $stable(r.cmd))
		else $error("command taken before previous answer");
	start_cond_a: assert property (r.run && r.step == Q_START &&
		r.ph == 2'h2 && r.qc == QW'(1) |-> !r.scl_low && r.sda_low)
		else $error("start condition not formed");
	reply_code_a: assert property (s_reply_entry |=> r.st == ST_TX &&
		r.tx_data == ($past(r.err) ? `STC_ERR : stc_reply($past(r.cmd))))
		else $error("wrong final answer byte");
	pkt_order_a: assert property (s_maddr_done ##0 pkt |-> r.step ==
		(r.cmd[7:4] == `STC_NIB_PKW ? Q_WDATA : Q_RSTART))
		else $error("packet phase order broken");
	clk9_free_a: assert property (r.run && r.step == Q_CLK9 |=>
		!r.sda_low && r.bitn <= `STC_ACK_BIT)
		else $error("data line pulled during recovery clocks");
	write_src_a: assert property (r.st == ST_BUS && !r.run &&
		r.step == Q_WDATA && !pkt |=> r.sh == $past(r.arg))
		else $error("write byte not taken from second byte");

	// Bus phase and handshake checks
	stop_cond_a: assert property (r.run && r.step == Q_STOP &&
		r.ph == 2'h3 && r.qc == QW'(1) |-> !r.scl_low && !r.sda_low)
		else $error("stop condition not formed");
	tx_hold_a: assert property (r.st == ST_TX |=>
		$stable(r.tx_data))
		else $error("answer byte changed while being sent");
	nack_stop_a: assert property ($past(r.run) && !r.run &&
		$past(r.nack) && $past(wr_step) && pkt |-> r.step == Q_STOP && r.err)
		else $error("packet byte NACK did not lead to stop and error");
	stretch_wait_a: assert property (stall |=>
		r.ph == 2'h1 && $stable(r.qc))
		else $error("clock phase moved while SCL held low");
endmodule
`default_nettype wire

// ==== tb/stc_slave_model.sv ====
// Purpose: behavioural 2-wire memory slave for the bridge bench
// Assumes: open-drain wires resolved by the bench, no clock stretching
// Notes: counts the master's ACK and NACK answers on read bytes
`default_nettype none
module stc_slave_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_low,
	output int n_ack,
	output int n_nak
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [256];
	logic [7:0] sh, ptr;
	logic act, adr, first, rw, rd;
	int bitn;
	initial begin
		sda_low = 1'b0;
		act = 1'b0;
		rd = 1'b0;
		n_ack = 0;
		n_nak = 0;
		bitn = 0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(~i);
	end
	// Start or repeated start
	always @(negedge sda) if (scl === 1'b1) begin
		act = 1'b1;
		adr = 1'b1;
		first = 1'b1;
		rd = 1'b0;
		bitn = 0;
		sda_low = 1'b0;
	end
	// Stop releases everything
	always @(posedge sda) if (scl === 1'b1) begin
		act = 1'b0;
		sda_low = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (bitn < 8) sh = {sh[6:0], sda};
		else if (rd) begin
			if (sda) begin
				n_nak++;
				act = 1'b0;
			end else n_ack++;
			ptr++;
		end
		bitn++;
	end
	// Data and ACK change only while SCL is low
	always @(negedge scl) if (act) begin
		if (bitn == 8) begin
			sda_low = 1'b0;
			if (adr) begin
				adr = 1'b0;
				rw = sh[0];
				if (sh[7:1] == ADDR) sda_low = 1'b1;
				else act = 1'b0;
			end else if (!rd) begin
				if (first) ptr = sh;
				else begin
					mem[ptr] = sh;
					ptr++;
				end
				first = 1'b0;
				sda_low = 1'b1;
			end
		end else if (bitn == 9) begin
			bitn = 0;
			rd = rw;
			sda_low = rw && !mem[ptr][7];
		end else if (rd) sda_low = !mem[ptr][7 - bitn];
	end
endmodule
`default_nettype wire

// ==== tb/test_stc_bridge.sv ====
// Purpose: self-checking bench of the serial to 2-wire bridge
// Assumes: QTR 8 and BAUD_DIV 8, slave at bus address 0xA0
// Notes: host side is a link_clk-paced 8N1 sender and a time-based receiver
`default_nettype none
module test_stc_bridge;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BIT = 1280;
	typedef struct packed {
		logic [2:0] ntx;
		logic [31:0] tx;
		logic [1:0] nrx;
		logic [23:0] rx;
	} stc_tb_row_t;
	logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, rxd = 1'b1;
	logic txd, scl_o, scl_oe, sda_o, sda_oe, slv_low;
	wire logic scl_w, sda_w;
	int n_ack, n_nak, miscompares = 0, tests_run = 0, ntest = 0, rises = 0;
	logic [7:0] rxq[$];
	logic [7:0] rb;
	stc_tb_row_t rows [20] = '{
		'{3'h2, 32'hA5A00000, 2'h1, 24'hB50000},
		'{3'h2, 32'hA5A10000, 2'h1, 24'hFA0000},
		'{3'h4, 32'h81101122, 2'h1, 24'h810000},
		'{3'h2, 32'h91100000, 2'h3, 24'h112291},
		'{3'h2, 32'hA0000000, 2'h1, 24'hB00000},
		'{3'h2, 32'hA1A00000, 2'h1, 24'hB10000},
		'{3'h2, 32'hA1100000, 2'h1, 24'hB10000},
		'{3'h2, 32'hA0000000, 2'h1, 24'hB00000},
		'{3'h2, 32'hA1A10000, 2'h1, 24'hB10000},
		'{3'h2, 32'hA2010000, 2'h2, 24'h11B200},
		'{3'h2, 32'hA2000000, 2'h2, 24'h22B200},
		'{3'h2, 32'hA3000000, 2'h1, 24'hB30000},
		'{3'h2, 32'h55000000, 2'h1, 24'hFA0000},
		'{3'h2, 32'hA5B00000, 2'h1, 24'hB50000},
		'{3'h2, 32'h91000000, 2'h1, 24'hFA0000},
		'{3'h3, 32'h80001100, 2'h1, 24'hFA0000},
		'{3'h2, 32'hA0000000, 2'h1, 24'hB00000},
		'{3'h2, 32'hA1B00000, 2'h1, 24'hFA0000},
		'{3'h2, 32'hA3000000, 2'h1, 24'hB30000},
		'{3'h2, 32'hA5A00000, 2'h1, 24'hB50000}};
	assign scl_w = scl_oe ? scl_o : 1'b1;
	assign sda_w = (sda_oe ? sda_o : 1'b1) && !slv_low;
	always #12.5 clk = ~clk;
	always #80 link_clk = ~link_clk;
	always @(posedge scl_w) rises++;
	stc_bridge #(.QTR(8), .BAUD_DIV(8)) dut (.clk(clk), .rst_n(rst_n),
		.link_clk(link_clk), .rxd(rxd), .txd(txd), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe));
	stc_slave_model #(.ADDR(7'h50)) slave (.scl(scl_w), .sda(sda_w),
		.sda_low(slv_low), .n_ack(n_ack), .n_nak(n_nak));
	// Host receiver collects answer bytes
	always begin
		@(negedge txd);
		#(BIT / 2);
		if (txd === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				#(BIT);
				rb[i] = txd;
			end
			#(BIT);
			rxq.push_back(rb);
		end
	end
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chkn(input string n, input int e, input int g);
		tests_run++;
		if (g != e) begin
			miscompares++;
			$display("mismatch %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge link_clk);
			#1 rxd = f[i];
			repeat (7) @(posedge link_clk);
		end
	endtask
	task automatic run(input logic [7:0] s[$], input logic [7:0] e[$]);
		int w;
		rxq.delete();
		foreach (s[i]) send(s[i]);
		w = 0;
		while (rxq.size() < e.size() && w < 40000) begin
			@(posedge clk);
			w++;
		end
		#8000;
		chkn("answer count", e.size(), rxq.size());
		foreach (e[i]) if (i < rxq.size()) chk8("answer", e[i], rxq[i]);
		chk1("scl_o", 1'b0, scl_o);
		chk1("sda_o", 1'b0, sda_o);
		ntest++;
		$display("test %0d done", ntest);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#2600000;
		miscompares++;
		$display("watchdog expired");
		final_report();
	end
	initial begin
		logic [7:0] s[$], e[$];
		int r0;
		repeat (4) @(posedge link_clk);
		chk1("txd in reset", 1'b1, txd);
		chk1("scl_oe in reset", 1'b0, scl_oe);
		chk1("sda_oe in reset", 1'b0, sda_oe);
		@(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge link_clk);
		foreach (rows[r]) begin
			s.delete();
			e.delete();
			for (int i = 0; i < rows[r].ntx; i++) s.push_back(rows[r].tx[31 - 8 * i -: 8]);
			for (int i = 0; i < rows[r].nrx; i++) e.push_back(rows[r].rx[23 - 8 * i -: 8]);
			run(s, e);
		end
		chkn("read acks", 2, n_ack);
		chkn("read nacks", 2, n_nak);
		// Longest packet write, bus idle until the last byte
		r0 = rises;
		s = '{8'h8F, 8'h40};
		for (int i = 0; i < 15; i++) s.push_back(8'(8'h30 + 7 * i));
		foreach (s[i]) send(s[i]);
		chkn("bus idle while buffering", r0, rises);
		run('{8'(8'h30 + 7 * 15)}, '{8'h8F});
		e.delete();
		for (int i = 0; i < 16; i++) e.push_back(8'(8'h30 + 7 * i));
		e.push_back(8'h9F);
		run('{8'h9F, 8'h40}, e);
		chkn("long read acks", 17, n_ack);
		chkn("long read nacks", 3, n_nak);
		// Recovery pulses, then a byte sent during execution is dropped
		r0 = rises;
		run('{8'hA4, 8'h00, 8'h55}, '{8'hB4});
		chkn("recovery pulses", r0 + 9, rises);
		run('{8'hA3, 8'h00}, '{8'hB3});
		// Reset between commands clears the packet device address
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (4) @(posedge link_clk);
		chk1("txd in reset", 1'b1, txd);
		chk1("scl_oe in reset", 1'b0, scl_oe);
		@(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge link_clk);
		run('{8'h90, 8'h00}, '{8'hFA});
		final_report();
	end
endmodule
`default_nettype wire
